// *** design/tcc_unit.v ***
// Timer capture/compare unit: two capture and two compare channels on a 16-bit counter.
// Assumes the surrounding timer supplies the counter, its tick and the mode selects,
// and that software reaches the byte-wide registers over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_unit_regs.vh"

// Functional notes
// - Active capture edge copies counter into capture register.
// - Capture registers read-only, high and low halves.
// - Per-channel edge select picks rising or falling.
// - One capture interrupt enable covers both channels.
// - Capture sets flag, holds counter at edge.
// - Capture interrupt needs enable and clear mask.
// - Capture flag clears: status read, then low access.
// - High byte read blocks captures until low read.
// - Capture register always holds the latest capture.
// - Captures and compares work at the same time.
// - One pulse or PWM: only channel two captures.
// - Capture pins always reach logic unless blocked.
// - Variant without channel two: flag zero, no registers.
// - Both compare values checked every timer tick.
// - Compare registers software owned, reset to 8000h.
// - Compare match sets the channel compare flag, except flag one in one pulse and both in PWM.
// - Match drives programmed level; pin low in reset.
// - Compare interrupt needs enable and clear mask.
// - Pin enable clear: no level, interrupt still possible.
// - Compare flag clears: status read, then low access.
// - High write suspends compare until low write.
// - Flag and pin update while counter equals value.
module tcc_unit #(
  parameter HAS_CAPTURE_TWO = 1,
  parameter CNT_W = 16
) (
  // Clock and reset.
  input wire ref_clk,
  input wire reset,
  // APB slave.
  input wire [`TCC_ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Surrounding timer.
  input wire [CNT_W-1:0] counter_value,
  input wire timer_tick,
  input wire one_pulse_select,
  input wire pwm_select,
  input wire counter_overflow_flag,
  input wire irq_mask,
  output reg timer_irq,
  // Pins.
  input wire capture_pin_one,
  input wire capture_pin_two,
  output reg compare_output_pin_one,
  output reg compare_output_pin_two,
  output reg compare_pin_enable_one,
  output reg compare_pin_enable_two
);

  // Control registers and derived status.
  reg [7:0] control_reg_one;
  reg [7:0] control_reg_two;
  wire [1:0] capture_flag;
  wire [1:0] compare_flag;
  wire [7:0] timer_status_reg;
  wire capture_irq_enable;
  wire compare_irq_enable;
  wire special_mode;
  wire [1:0] cap_pin_raw;
  wire [1:0] cmp_level_out;
  wire [1:0] cmp_level_hit;

  // Bus phases: the access completes on the edge where pready is high.
  wire bus_access;
  wire bus_done;
  wire wr_done;
  wire rd_done;
  reg [31:0] next_prdata;
  reg next_err;

  // Bus strobes, control fields and the status byte as software sees it.
  assign bus_access = psel & penable;
  assign bus_done = bus_access & pready;
  assign wr_done = bus_done & pwrite;
  assign rd_done = bus_done & ~pwrite;
  assign capture_irq_enable = control_reg_one[`TCC_CR1_CAP_IE_BIT];
  assign compare_irq_enable = control_reg_one[`TCC_CR1_CMP_IE_BIT];
  assign special_mode = one_pulse_select | pwm_select;
  assign cap_pin_raw = {capture_pin_two, capture_pin_one};
  assign timer_status_reg = {3'h0, counter_overflow_flag, compare_flag, capture_flag};

  // Per-channel capture and compare logic.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : ch
      // Byte addresses of this channel's register halves, cut to the bus address width.
      localparam [31:0] CAP_HI_FULL = `TCC_CAP_HIGH_BASE + i * `TCC_CH_STRIDE;
      localparam [31:0] CAP_LO_FULL = `TCC_CAP_LOW_BASE + i * `TCC_CH_STRIDE;
      localparam [31:0] CMP_HI_FULL = `TCC_CMP_HIGH_BASE + i * `TCC_CH_STRIDE;
      localparam [31:0] CMP_LO_FULL = `TCC_CMP_LOW_BASE + i * `TCC_CH_STRIDE;
      localparam [7:0] CAP_HI = CAP_HI_FULL[7:0];
      localparam [7:0] CAP_LO = CAP_LO_FULL[7:0];
      localparam [7:0] CMP_HI = CMP_HI_FULL[7:0];
      localparam [7:0] CMP_LO = CMP_LO_FULL[7:0];
      localparam PRESENT = (i == 0) || (HAS_CAPTURE_TWO != 0);
      reg pin_meta;
      reg pin_sync;
      reg pin_prev;
      reg [CNT_W-1:0] cap_val;
      reg cap_flag;
      reg cap_armed;
      reg cap_locked;
      reg [CNT_W-1:0] cmp_val;
      reg cmp_flag;
      reg cmp_armed;
      reg cmp_suspended;
      wire edge_sel;
      wire cap_edge;
      wire cap_allowed;
      wire cap_event;
      wire cap_low_access;
      wire cmp_low_access;
      wire cmp_flag_allowed;
      wire cmp_hit;

      assign edge_sel = control_reg_one[`TCC_CR1_EDGE_LSB + i];
      // Rising when the select bit is set, falling otherwise.
      assign cap_edge = edge_sel ? (pin_sync & ~pin_prev) : (~pin_sync & pin_prev);
      // Channel one is taken over by the waveform modes.
      assign cap_allowed = PRESENT && !cap_locked && !(i == 0 && special_mode);
      assign cap_event = cap_edge & cap_allowed;
      // Clearing accesses count only on the completing edge of a transfer.
      assign cap_low_access = bus_done & (paddr == CAP_LO);
      assign cmp_low_access = bus_done & (paddr == CMP_LO);
      // One pulse blocks flag one; PWM blocks both.
      assign cmp_flag_allowed = !pwm_select && !(i == 0 && one_pulse_select);
      // Comparison runs on each timer tick while the value equals the counter.
      assign cmp_hit = timer_tick & ~cmp_suspended & (counter_value == cmp_val);

      // Pin synchroniser and edge history; the first stage feeds only the second.
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          pin_meta <= 1'b0;
          pin_sync <= 1'b0;
          pin_prev <= 1'b0;
        end
        else
        begin
          pin_meta <= cap_pin_raw[i];
          pin_sync <= pin_meta;
          pin_prev <= pin_sync;
        end
      end

      // Capture register, flag, clear handshake and high-byte lock.
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          cap_val <= {CNT_W{1'b0}};
          cap_flag <= 1'b0;
          cap_armed <= 1'b0;
          cap_locked <= 1'b0;
        end
        else
        begin
          if (cap_event)
            cap_val <= counter_value;
          // A capture in the same cycle as the clearing access wins, so no event is lost.
          if (cap_event)
            cap_flag <= 1'b1;
          else if (cap_low_access && cap_armed)
            cap_flag <= 1'b0;
          if (cap_low_access)
            cap_armed <= 1'b0;
          else if (rd_done && paddr == `TCC_STATUS_ADDR && cap_flag)
            cap_armed <= 1'b1;
          // The lock is taken by a high-byte read and dropped by the matching low-byte read.
          if (rd_done && paddr == CAP_HI)
            cap_locked <= 1'b1;
          else if (rd_done && paddr == CAP_LO)
            cap_locked <= 1'b0;
        end
      end

      // Compare register, flag, clear handshake and write suspension.
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          cmp_val <= `TCC_CMP_RESET;
          cmp_flag <= 1'b0;
          cmp_armed <= 1'b0;
          cmp_suspended <= 1'b0;
        end
        else
        begin
          // A high-byte write holds comparisons off, so a half-written value never matches.
          if (wr_done && paddr == CMP_HI)
          begin
            cmp_val[CNT_W-1:8] <= pwdata[CNT_W-9:0];
            cmp_suspended <= 1'b1;
          end
          if (wr_done && paddr == CMP_LO)
          begin
            cmp_val[7:0] <= pwdata[7:0];
            cmp_suspended <= 1'b0;
          end
          // A match in the same cycle as the clearing access wins over the clear.
          if (cmp_hit && cmp_flag_allowed)
            cmp_flag <= 1'b1;
          else if (cmp_low_access && cmp_armed)
            cmp_flag <= 1'b0;
          if (cmp_low_access)
            cmp_armed <= 1'b0;
          else if (rd_done && paddr == `TCC_STATUS_ADDR && cmp_flag)
            cmp_armed <= 1'b1;
        end
      end

      // A missing second capture channel shows a flag that never sets.
      assign capture_flag[i] = PRESENT ? cap_flag : 1'b0;
      assign compare_flag[i] = cmp_flag;
      assign cmp_level_hit[i] = cmp_hit & control_reg_two[`TCC_CR2_PIN_EN_LSB + i];
      assign cmp_level_out[i] = control_reg_one[`TCC_CR1_LEVEL_LSB + i];
    end
  endgenerate

  // Control registers written by software.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      control_reg_one <= `TCC_CR1_RESET;
      control_reg_two <= `TCC_CR2_RESET;
    end
    else
    begin
      if (wr_done && paddr == `TCC_CTRL_ONE_ADDR)
        control_reg_one <= pwdata[7:0];
      if (wr_done && paddr == `TCC_CTRL_TWO_ADDR)
        control_reg_two <= pwdata[7:0];
    end
  end

  // Compare pins take the programmed level on a match; the latches start low.
  // The enables are registered copies, so every top-level output leaves a flop.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      compare_output_pin_one <= 1'b0;
      compare_output_pin_two <= 1'b0;
      compare_pin_enable_one <= 1'b0;
      compare_pin_enable_two <= 1'b0;
    end
    else
    begin
      if (cmp_level_hit[0])
        compare_output_pin_one <= cmp_level_out[0];
      if (cmp_level_hit[1])
        compare_output_pin_two <= cmp_level_out[1];
      compare_pin_enable_one <= control_reg_two[`TCC_CR2_PIN_EN_LSB];
      compare_pin_enable_two <= control_reg_two[`TCC_CR2_PIN_EN_LSB + 1];
    end
  end

  // Interrupt request stays pending while the global mask is set.
  // Flags are levels, so a masked request reappears as soon as the mask drops.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      timer_irq <= 1'b0;
    else
      timer_irq <= ~irq_mask & ((capture_irq_enable & (|capture_flag))
        | (compare_irq_enable & (|compare_flag)));
  end

  // Read data and decode; capture halves are read-only, writes to them are dropped.
  // Read data is loaded one edge ahead of completion; side effects wait for that edge.
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `TCC_CAP_HIGH_BASE:
        next_prdata[7:0] = ch[0].cap_val[CNT_W-1:8];
      `TCC_CAP_LOW_BASE:
        next_prdata[7:0] = ch[0].cap_val[7:0];
      `TCC_CAP_HIGH_BASE + `TCC_CH_STRIDE:
        next_prdata[7:0] = (HAS_CAPTURE_TWO != 0) ? ch[1].cap_val[CNT_W-1:8] : 8'h00;
      `TCC_CAP_LOW_BASE + `TCC_CH_STRIDE:
        next_prdata[7:0] = (HAS_CAPTURE_TWO != 0) ? ch[1].cap_val[7:0] : 8'h00;
      `TCC_CMP_HIGH_BASE:
        next_prdata[7:0] = ch[0].cmp_val[CNT_W-1:8];
      `TCC_CMP_LOW_BASE:
        next_prdata[7:0] = ch[0].cmp_val[7:0];
      `TCC_CMP_HIGH_BASE + `TCC_CH_STRIDE:
        next_prdata[7:0] = ch[1].cmp_val[CNT_W-1:8];
      `TCC_CMP_LOW_BASE + `TCC_CH_STRIDE:
        next_prdata[7:0] = ch[1].cmp_val[7:0];
      `TCC_STATUS_ADDR:
        next_prdata[7:0] = timer_status_reg;
      `TCC_CTRL_ONE_ADDR:
        next_prdata[7:0] = control_reg_one;
      `TCC_CTRL_TWO_ADDR:
        next_prdata[7:0] = control_reg_two;
      default:
        next_err = 1'b1;
    endcase
  end

  // APB handshake: one wait state, then pready for exactly one cycle.
  // Writes to read-only or status addresses finish normally; a write to a capture low half still counts as its flag-clearing access.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (bus_access && !pready)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_err;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // tcc_unit
`default_nettype wire

// *** design/tcc_unit_regs.vh ***
// Register map, field positions and reset values of the timer capture/compare unit.
// Assumes a 32-bit APB with byte addresses; the registers use the low byte only.
`ifndef TCC_UNIT_REGS_VH
`define TCC_UNIT_REGS_VH

// Address width of the register window.
`define TCC_ADDR_W 8
// Capture value halves: channel n sits at base + n * stride.
`define TCC_CAP_HIGH_BASE 8'h00
`define TCC_CAP_LOW_BASE 8'h04
// Compare value halves: channel n sits at base + n * stride.
`define TCC_CMP_HIGH_BASE 8'h10
`define TCC_CMP_LOW_BASE 8'h14
`define TCC_CH_STRIDE 8'h08
// Status and control registers.
`define TCC_STATUS_ADDR 8'h20
`define TCC_CTRL_ONE_ADDR 8'h24
`define TCC_CTRL_TWO_ADDR 8'h28

// Status register fields.
`define TCC_SR_CAPF_LSB 0
`define TCC_SR_CMPF_LSB 2
`define TCC_SR_OVF_BIT 4
// Control register one fields.
`define TCC_CR1_CAP_IE_BIT 0
`define TCC_CR1_CMP_IE_BIT 1
`define TCC_CR1_EDGE_LSB 2
`define TCC_CR1_LEVEL_LSB 4
// Control register two fields.
`define TCC_CR2_PIN_EN_LSB 0

// Reset values.
`define TCC_CMP_RESET 16'h8000
`define TCC_CR1_RESET 8'h00
`define TCC_CR2_RESET 8'h00

`endif

// *** tb/tb.sv ***
// Self-checking bench for the capture/compare unit over APB.
// Assumes the register map header and the pin model beside the unit.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_unit_regs.vh"
module tb;
  logic ref_clk, reset, psel, penable, pwrite, timer_tick, irq_mask, ovf, want_one, want_two;
  logic pready, pslverr, err, timer_irq, pin_one, pin_two, en_one, en_two, cap_one, cap_two;
  logic one_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] counter_value;
  integer errors, n_tests, i;

  tcc_unit uut (.ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value), .timer_tick(timer_tick),
    .one_pulse_select(one_pulse), .pwm_select(1'b0), .counter_overflow_flag(ovf),
    .irq_mask(irq_mask), .timer_irq(timer_irq), .capture_pin_one(cap_one),
    .capture_pin_two(cap_two), .compare_output_pin_one(pin_one),
    .compare_output_pin_two(pin_two), .compare_pin_enable_one(en_one),
    .compare_pin_enable_two(en_two));
  tcc_pin_model pins (.ref_clk(ref_clk), .reset(reset), .want_one(want_one),
    .want_two(want_two), .capture_pin_one(cap_one), .capture_pin_two(cap_two));

  // Free-running 100 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compares one value and counts it.
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("FAIL %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // One APB transfer, driven just after rising edges; the answer is looked at on the
  // falling edge, where it shows what the completing rising edge samples.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(negedge ref_clk);
      while (pready !== 1'b1 && n < 20)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n == 20)
        errors = errors + 1;
      rd = prdata;
      err = pslverr;
      @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  // Reads a register and compares its byte.
  task rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    begin
      apb(1'b0, a, 8'h00);
      check(name, {24'h000000, exp}, rd);
    end
  endtask

  // One timer tick at the given count, then time for flag and interrupt.
  task tick(input logic [15:0] v);
    begin
      counter_value <= v;
      timer_tick <= 1'b1;
      @(posedge ref_clk);
      timer_tick <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask

  // Moves a capture pin at a held count and waits past synchronisation.
  task pin(input logic two, input logic lvl, input logic [15:0] v);
    begin
      counter_value <= v;
      if (two)
        want_two <= lvl;
      else
        want_one <= lvl;
      repeat (6) @(posedge ref_clk);
    end
  endtask

  // Prints the verdict and ends the run.
  task finish_test;
    begin
      if (errors == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    errors = errors + 1;
    finish_test;
  end

  // Main sequence.
  initial
  begin
    {errors, n_tests} = 0;
    {reset, psel, penable, pwrite, timer_tick, ovf, want_one, one_pulse} = 8'b10000000;
    {irq_mask, want_two, paddr, pwdata, counter_value} = {2'b11, 56'h0};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 2; i = i + 1)
    begin
      rdc("cmp_high", `TCC_CMP_HIGH_BASE + i * `TCC_CH_STRIDE, 8'h80);
      rdc("cmp_low", `TCC_CMP_LOW_BASE + i * `TCC_CH_STRIDE, 8'h00);
    end
    apb(1'b1, `TCC_CTRL_ONE_ADDR, 8'h32);
    apb(1'b1, `TCC_CTRL_TWO_ADDR, 8'h01);
    @(negedge ref_clk);
    check("pin_enable", 32'h2, {30'h0, en_one, en_two});
    apb(1'b1, `TCC_CMP_HIGH_BASE, 8'h12);
    tick(16'h1200);
    rdc("status_held", `TCC_STATUS_ADDR, 8'h00);
    apb(1'b1, `TCC_CMP_LOW_BASE, 8'h34);
    tick(16'h1234);
    tick(16'h8000);
    @(negedge ref_clk);
    check("pins", 32'h2, {30'h0, pin_one, pin_two});
    check("irq_masked", 32'h0, {31'h0, timer_irq});
    rdc("status_cmp", `TCC_STATUS_ADDR, 8'h0C);
    irq_mask <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("irq_pending", 32'h1, {31'h0, timer_irq});
    apb(1'b1, `TCC_CMP_LOW_BASE, 8'h34);
    rdc("cmp2_low", `TCC_CMP_LOW_BASE + `TCC_CH_STRIDE, 8'h00);
    rdc("status_clr", `TCC_STATUS_ADDR, 8'h00);
    apb(1'b1, `TCC_CTRL_ONE_ADDR, 8'h05);
    pin(1'b0, 1'b1, 16'hA55A);
    pin(1'b1, 1'b0, 16'h0F0E);
    @(negedge ref_clk);
    check("irq_capture", 32'h1, {31'h0, timer_irq});
    rdc("status_cap", `TCC_STATUS_ADDR, 8'h03);
    rdc("cap1_high", `TCC_CAP_HIGH_BASE, 8'hA5);
    pin(1'b0, 1'b0, 16'h1111);
    pin(1'b0, 1'b1, 16'h1111);
    rdc("cap1_locked", `TCC_CAP_LOW_BASE, 8'h5A);
    rdc("status_lock", `TCC_STATUS_ADDR, 8'h02);
    pin(1'b0, 1'b0, 16'h3333);
    pin(1'b0, 1'b1, 16'h2B1C);
    apb(1'b1, `TCC_CAP_HIGH_BASE, 8'hFF);
    rdc("cap1_high_new", `TCC_CAP_HIGH_BASE, 8'h2B);
    rdc("cap1_low_new", `TCC_CAP_LOW_BASE, 8'h1C);
    rdc("cap2_high", `TCC_CAP_HIGH_BASE + `TCC_CH_STRIDE, 8'h0F);
    rdc("cap2_low", `TCC_CAP_LOW_BASE + `TCC_CH_STRIDE, 8'h0E);
    ovf <= 1'b1;
    rdc("status_end", `TCC_STATUS_ADDR, 8'h11);
    rdc("cap1_low_clr", `TCC_CAP_LOW_BASE, 8'h1C);
    one_pulse <= 1'b1;
    pin(1'b0, 1'b0, 16'h4444);
    pin(1'b0, 1'b1, 16'h4444);
    tick(16'h1234);
    @(negedge ref_clk);
    check("opm_pin", 32'h0, {31'h0, pin_one});
    rdc("status_opm", `TCC_STATUS_ADDR, 8'h10);
    rdc("cap1_opm", `TCC_CAP_HIGH_BASE, 8'h2B);
    apb(1'b0, 8'h30, 8'h00);
    check("unmapped", 32'h1, {31'h0, err});
    finish_test;
  end
endmodule // tb
`default_nettype wire

// *** tb/tcc_pin_model.sv ***
// External drivers of the two capture pins.
// Assumes the bench asks for levels; the pins move just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Wanted levels.
  input wire logic want_one,
  input wire logic want_two,
  // Capture pins.
  output var logic capture_pin_one,
  output var logic capture_pin_two
);
  // Pins are always driven, so every step reaches the capture inputs; they rest low in reset.
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      capture_pin_one <= 1'b0;
      capture_pin_two <= 1'b0;
    end
    else
    begin
      capture_pin_one <= want_one;
      capture_pin_two <= want_two;
    end
  end
endmodule // tcc_pin_model
`default_nettype wire

// *** tb/tcc_unit_asserts.sv ***
// Checker for the capture/compare unit: bus answers, pin timing and interrupt masking.
// Assumes it is bound to tcc_unit and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tcc_unit_asserts (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Bus side.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer side and pins.
  input wire logic timer_tick,
  input wire logic irq_mask,
  input wire logic timer_irq,
  input wire logic compare_output_pin_one,
  input wire logic compare_output_pin_two
);
  // Every check uses the one clock and pauses while reset is high.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stayed high");
  property p_ready_access;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready without a full access phase");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr outside an answer");
  property p_byte_wide;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_byte_wide: assert property (p_byte_wide)
    else $error("read data above the byte");
  property p_write_zero;
    pready && pwrite |-> prdata == 32'h00000000;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("read data on a write");
  property p_pin_reset_low;
    $fell(reset) |-> !compare_output_pin_one && !compare_output_pin_two;
  endproperty
  a_pin_reset_low: assert property (p_pin_reset_low)
    else $error("compare pin not low after reset");
  property p_pin_on_tick;
    $changed(compare_output_pin_one) || $changed(compare_output_pin_two) |-> $past(timer_tick);
  endproperty
  a_pin_on_tick: assert property (p_pin_on_tick)
    else $error("compare pin moved without a timer tick");
  property p_irq_masked;
    irq_mask |=> !timer_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised while masked");
endmodule // tcc_unit_asserts

bind tcc_unit tcc_unit_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_tick(timer_tick), .irq_mask(irq_mask), .timer_irq(timer_irq),
  .compare_output_pin_one(compare_output_pin_one),
  .compare_output_pin_two(compare_output_pin_two));
`default_nettype wire
